// ==== tb/host_bus_model.sv ====
`timescale 1ns/1ps
module host_bus_model (
  input wire logic sys_clk_in,
  output logic chip_select_low_n_out,
  output logic chip_select_high_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic [11:0] bus_data_out,
  input wire logic [11:0] bus_rd_data_in
);
  // Idle bus
  initial
  begin
    {chip_select_low_n_out, chip_select_high_out} = 2'b10;
    {read_strobe_n_out, write_strobe_n_out} = 2'b11;
    bus_data_out = 12'h000;
  end
  ////////////////////////////////////////////////////////////
  // Register write, strobe held over one sampling edge
  task automatic write_reg(input logic [1:0] sel, input logic [9:0] value);
    @(negedge sys_clk_in);
    {chip_select_low_n_out, chip_select_high_out, write_strobe_n_out} = 3'b010;
    bus_data_out = {sel, value};
    @(negedge sys_clk_in);
    {chip_select_low_n_out, chip_select_high_out, write_strobe_n_out} = 3'b101;
    bus_data_out = ~bus_data_out;
    @(negedge sys_clk_in);
  endtask
  // One sample per strobe, data taken a cycle after the strobe edge
  task automatic read_word(output logic [11:0] value);
    @(negedge sys_clk_in);
    {chip_select_low_n_out, chip_select_high_out, read_strobe_n_out} = 3'b010;
    @(negedge sys_clk_in);
    {chip_select_low_n_out, chip_select_high_out, read_strobe_n_out} = 3'b101;
    @(negedge sys_clk_in);
    value = bus_rd_data_in;
  endtask
endmodule

// ==== tb/sample_buffer_port_checker.sv ====
`timescale 1ns/1ps
module sample_buffer_port_checker (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic chip_select_low_n_in,
  input wire logic chip_select_high_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [11:0] bus_data_in,
  input wire logic [11:0] bus_data_out,
  input wire logic bus_data_oe_out,
  input wire logic samples_ready_n_out,
  input wire logic ref_external_out,
  input wire logic power_down_out,
  input wire logic hold_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////
  // Qualified strobes and their first cycle
  wire sel = !chip_select_low_n_in && chip_select_high_in;
  wire rd_act = sel && !read_strobe_n_in;
  wire wr_act = sel && !write_strobe_n_in;
  logic rd_q_ff;
  logic wr_q_ff;
  wire rd_start = rd_act && !rd_q_ff;
  wire wr_start = wr_act && !wr_q_ff;
  // Previous strobe levels
  always_ff @(posedge sys_clk_in)
  begin
    rd_q_ff <= rd_act;
    wr_q_ff <= wr_act;
  end
  ////////////////////////////////////////////////////////////
  property p_ref_write;
    wr_start && bus_data_in[11:10] == 2'h0 |=> ref_external_out == $past(bus_data_in[0]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("reference bit not loaded");
  property p_pd_write;
    wr_start && bus_data_in[11:10] == 2'h0 |=> power_down_out == $past(bus_data_in[2]);
  endproperty
  a_pd_write: assert property (p_pd_write) else $error("power down bit not loaded");
  property p_reserved;
    wr_start && bus_data_in[11] |=> $stable(ref_external_out) && $stable(power_down_out);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code changed state");
  property p_second_sel;
    wr_start && bus_data_in[11:10] == 2'h1 |=> $stable(ref_external_out);
  endproperty
  a_second_sel: assert property (p_second_sel) else $error("wrong register written");
  property p_oe;
    1'b1 |=> bus_data_oe_out == $past(rd_act);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable not tied to read");
  property p_data_hold;
    !rd_start && !wr_act |=> $stable(bus_data_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved without read");
  property p_ready_pulse;
    $fell(samples_ready_n_out) |=> samples_ready_n_out;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready not a pulse");
  property p_hold_pulse;
    hold_out |=> !hold_out;
  endproperty
  a_hold_pulse: assert property (p_hold_pulse) else $error("hold not a pulse");
  c_pulse: cover property ($fell(samples_ready_n_out));
  c_hold: cover property (hold_out);
  c_read: cover property (rd_start);
endmodule

// ==== tb/test_adc_sample_fifo_host_port.sv ====
`timescale 1ns/1ps
module test_adc_sample_fifo_host_port;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic conversion_clock = 1'b0;
  logic [11:0] res_a = 12'h000;
  logic [11:0] res_b = 12'h000;
  logic csl_n, csh, rd_n, wr_n, oe, ready_n, ovf, ref_ext, pd, hold;
  logic [11:0] wdata, rdata;
  logic seen_ready, seen_hold;
  int err_total = 0;
  int compares = 0;
  int edges = 0;
  // Bus clock
  initial
  begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  sample_buffer_port sample_buffer_port_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .conversion_clock_in(conversion_clock), .result_a_in(res_a), .result_b_in(res_b),
    .chip_select_low_n_in(csl_n), .chip_select_high_in(csh), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .bus_data_in(wdata), .bus_data_out(rdata),
    .bus_data_oe_out(oe), .samples_ready_n_out(ready_n), .overflow_out(ovf),
    .ref_external_out(ref_ext), .power_down_out(pd), .hold_out(hold));
  host_bus_model host_bus_model_i (.sys_clk_in(sys_clk_in), .chip_select_low_n_out(csl_n),
    .chip_select_high_out(csh), .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
    .bus_data_out(wdata), .bus_rd_data_in(rdata));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One conversion clock period: 4 cycles high, 12 low, watching pulses
  task automatic conv_edge();
    edges++;
    seen_ready = 1'b0;
    seen_hold = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge sys_clk_in);
      res_a = edges[11:0];
      res_b = edges[11:0] | 12'h800;
      conversion_clock = (i < 4);
      seen_ready |= (ready_n === 1'b0);
      seen_hold |= (hold === 1'b1);
    end
  endtask
  task automatic wait_ready(input int bound);
    seen_ready = 1'b0;
    for (int n = 0; n < bound && !seen_ready; n++)
      conv_edge();
    if (!seen_ready)
    begin
      $display("CHECK FAILED at %0t: no data-available pulse in bound", $time);
      err_total++;
      wrap_up();
    end
  endtask
  task automatic restart(input logic [9:0] mode, input logic [1:0] trig);
    host_bus_model_i.write_reg(2'h0, mode);
    host_bus_model_i.write_reg(2'h1, {6'h00, trig, 2'b10});
    host_bus_model_i.write_reg(2'h1, {6'h00, trig, 2'b00});
    edges = 0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_registers();
    logic [11:0] got;
    check({10'h000, pd, ref_ext}, 12'h000, "reset bits");
    host_bus_model_i.write_reg(2'h0, 10'h025);
    check({10'h000, pd, ref_ext}, 12'h003, "first register");
    host_bus_model_i.write_reg(2'h2, 10'h020);
    host_bus_model_i.write_reg(2'h3, 10'h020);
    check({10'h000, pd, ref_ext}, 12'h003, "reserved codes");
    host_bus_model_i.write_reg(2'h1, 10'h000);
    check({10'h000, pd, ref_ext}, 12'h003, "second select");
    host_bus_model_i.write_reg(2'h1, 10'h200);
    host_bus_model_i.read_word(got);
    check(got, 12'h025, "readback first register");
    host_bus_model_i.write_reg(2'h1, 10'h204);
    host_bus_model_i.read_word(got);
    check(got, 12'h204, "readback second register");
  endtask
  task automatic t_levels();
    logic [11:0] got;
    int lv;
    for (int c = 0; c < 4; c++)
    begin
      lv = (c == 0) ? 1 : (c == 3) ? 14 : 4 * c;
      restart(10'h020, c[1:0]);
      wait_ready(30);
      check(edges[11:0], 12'(7 + lv), "edges to first pulse");
      for (int k = 0; k < lv; k++)
      begin
        host_bus_model_i.read_word(got);
        check(got, 12'(8 + k), "sample order");
      end
    end
  endtask
  task automatic t_scan();
    logic [11:0] a;
    logic [11:0] b;
    restart(10'h088, 2'h0);
    wait_ready(12);
    host_bus_model_i.read_word(a);
    host_bus_model_i.read_word(b);
    check(a & 12'h800, 12'h000, "block starts on first input");
    check(b, (a + 12'h001) | 12'h800, "scan order");
  endtask
  task automatic t_single();
    logic [11:0] got;
    restart(10'h022, 2'h0);
    conv_edge();
    check({10'h000, seen_hold, seen_ready}, 12'h003, "single start");
    host_bus_model_i.read_word(got);
    check(got, 12'h001, "single sample");
    restart(10'h08a, 2'h0);
    conv_edge();
    check({10'h000, seen_hold, seen_ready}, 12'h003, "scan single start");
    host_bus_model_i.read_word(got);
    check(got, 12'h001, "scan single first input");
    host_bus_model_i.read_word(got);
    check(got, 12'h801, "scan single second input");
  endtask
  task automatic t_overflow();
    restart(10'h020, 2'h3);
    repeat (23) conv_edge();
    check({11'h000, ovf}, 12'h000, "sixteen held");
    repeat (10) conv_edge();
    check({11'h000, ovf}, 12'h001, "overflow flagged");
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_registers();
    t_levels();
    t_scan();
    t_single();
    t_overflow();
    wrap_up();
  end
endmodule
bind sample_buffer_port sample_buffer_port_checker sample_buffer_port_checker_i (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .chip_select_low_n_in(chip_select_low_n_in),
  .chip_select_high_in(chip_select_high_in), .read_strobe_n_in(read_strobe_n_in),
  .write_strobe_n_in(write_strobe_n_in), .bus_data_in(bus_data_in),
  .bus_data_out(bus_data_out), .bus_data_oe_out(bus_data_oe_out),
  .samples_ready_n_out(samples_ready_n_out), .ref_external_out(ref_external_out),
  .power_down_out(power_down_out), .hold_out(hold_out));

// ==== verilog/sample_buffer_pkg.sv ====
package sample_buffer_pkg;

  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned CFG_W = 10;
  localparam int unsigned BUF_DEPTH = 16;
  localparam int unsigned PIPE_LATENCY = 7;

  // Register select codes on bus lines 10 and 11
  localparam logic [1:0] SEL_CONVERSION = 2'h0;
  localparam logic [1:0] SEL_FIFO_OUTPUT = 2'h1;

  // Reset values
  localparam logic [9:0] CONVERSION_RESET = 10'h020;
  localparam logic [9:0] FIFO_OUTPUT_RESET = 10'h000;

  // First register field positions
  localparam int unsigned REF_SEL_BIT = 0;
  localparam int unsigned SINGLE_MODE_BIT = 1;
  localparam int unsigned POWER_DOWN_BIT = 2;
  localparam int unsigned INPUT_SEL_LO_BIT = 3;
  localparam int unsigned DIFF_COUNT_LO_BIT = 5;
  localparam int unsigned SCAN_BIT = 7;
  localparam int unsigned TEST_SEL_LO_BIT = 8;

  // Second register field positions
  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam int unsigned BUFFER_RESET_BIT = 1;
  localparam int unsigned TRIGGER_LEVEL_LO_BIT = 2;
  localparam int unsigned NUMBER_FORMAT_BIT = 7;
  localparam int unsigned READBACK_BIT = 9;

  // Trigger levels, indexed by trigger code, single and scan input
  localparam logic [4:0] LEVEL_SINGLE_0 = 5'h01;
  localparam logic [4:0] LEVEL_SINGLE_1 = 5'h04;
  localparam logic [4:0] LEVEL_SINGLE_2 = 5'h08;
  localparam logic [4:0] LEVEL_SINGLE_3 = 5'h0e;
  localparam logic [4:0] LEVEL_SCAN_0 = 5'h02;
  localparam logic [4:0] LEVEL_SCAN_1 = 5'h04;
  localparam logic [4:0] LEVEL_SCAN_2 = 5'h08;
  localparam logic [4:0] LEVEL_SCAN_3 = 5'h0c;

  typedef struct packed {
    logic [1:0] test_sel;
    logic scan_enable;
    logic [1:0] diff_count;
    logic [1:0] input_sel;
    logic power_down;
    logic single_mode;
    logic ref_external;
  } conversion_setup_s;

  typedef struct packed {
    logic register_readback;
    logic offset;
    logic number_format;
    logic read_write;
    logic [1:0] output_polarity;
    logic [1:0] trigger_level;
    logic overflow_or_buffer_reset;
    logic soft_reset;
  } fifo_output_setup_s;

  typedef struct packed {
    logic channel;
    logic [SAMPLE_W-1:0] value;
  } sample_s;

endpackage

// ==== verilog/sample_buffer_port.sv ====
`timescale 1ns/1ps
module sample_buffer_port #(
  parameter int unsigned DEPTH = sample_buffer_pkg::BUF_DEPTH,
  parameter int unsigned STAGE_DEPTH = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic conversion_clock_in,
  input wire logic [sample_buffer_pkg::SAMPLE_W-1:0] result_a_in,
  input wire logic [sample_buffer_pkg::SAMPLE_W-1:0] result_b_in,
  input wire logic chip_select_low_n_in,
  input wire logic chip_select_high_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [11:0] bus_data_in,
  output logic [11:0] bus_data_out,
  output logic bus_data_oe_out,
  output logic samples_ready_n_out,
  output logic overflow_out,
  output logic ref_external_out,
  output logic power_down_out,
  output logic hold_out
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned SW = sample_buffer_pkg::SAMPLE_W + 1;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  sample_buffer_pkg::conversion_setup_s conversion_setup_ff;
  sample_buffer_pkg::fifo_output_setup_s fifo_output_setup_ff;
  logic wr_n_d_ff;
  logic rd_n_d_ff;
  logic clk_d_ff;

  wire selected = !chip_select_low_n_in && chip_select_high_in;
  wire write_edge = selected && !write_strobe_n_in && wr_n_d_ff;
  wire [1:0] reg_sel = bus_data_in[11:10];
  wire write_conv = write_edge && (reg_sel == sample_buffer_pkg::SEL_CONVERSION);
  wire write_fifo = write_edge && (reg_sel == sample_buffer_pkg::SEL_FIFO_OUTPUT);
  wire read_active = selected && !read_strobe_n_in;
  wire read_edge = read_active && rd_n_d_ff;
  wire readback = fifo_output_setup_ff.register_readback;
  wire buffer_reset = write_fifo && bus_data_in[sample_buffer_pkg::BUFFER_RESET_BIT];
  wire soft_reset = write_fifo && bus_data_in[sample_buffer_pkg::SOFT_RESET_BIT];
  wire clear_all = rst_in || soft_reset || buffer_reset;

  // Register writes on strobe falling edge, ten value bits kept
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || soft_reset)
    begin
      conversion_setup_ff <= sample_buffer_pkg::CONVERSION_RESET;
      fifo_output_setup_ff <= sample_buffer_pkg::FIFO_OUTPUT_RESET;
    end
    else
    begin
      if (write_conv)
        conversion_setup_ff <= bus_data_in[9:0];
      if (write_fifo)
        fifo_output_setup_ff <= bus_data_in[9:0];
    end
  end

  // Strobe history, so each strobe acts once at its falling edge
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      wr_n_d_ff <= 1'b1;
      rd_n_d_ff <= 1'b1;
    end
    else
    begin
      wr_n_d_ff <= !(selected && !write_strobe_n_in);
      rd_n_d_ff <= !read_active;
    end
  end

  // Conversion clock history; resets low so reset gives no false fall
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      clk_d_ff <= 1'b0;
    else
      clk_d_ff <= conversion_clock_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing

  wire scan = conversion_setup_ff.scan_enable;
  wire single_mode = conversion_setup_ff.single_mode;
  wire [1:0] trigger_code = fifo_output_setup_ff.trigger_level;
  wire clk_fall = clk_d_ff && !conversion_clock_in;
  logic [4:0] level;
  logic [3:0] latency_ff;
  logic chan_ff;
  logic second_pending_ff;

  // Trigger level lookup by input count
  always_comb
  begin
    level = sample_buffer_pkg::LEVEL_SINGLE_0;
    case ({scan, trigger_code})
      3'h0: level = sample_buffer_pkg::LEVEL_SINGLE_0;
      3'h1: level = sample_buffer_pkg::LEVEL_SINGLE_1;
      3'h2: level = sample_buffer_pkg::LEVEL_SINGLE_2;
      3'h3: level = sample_buffer_pkg::LEVEL_SINGLE_3;
      3'h4: level = sample_buffer_pkg::LEVEL_SCAN_0;
      3'h5: level = sample_buffer_pkg::LEVEL_SCAN_1;
      3'h6: level = sample_buffer_pkg::LEVEL_SCAN_2;
      3'h7: level = sample_buffer_pkg::LEVEL_SCAN_3;
      default: level = sample_buffer_pkg::LEVEL_SINGLE_0;
    endcase
  end

  // Pipeline fill: first results dropped after buffer reset in continuous mode; single mode stores from the first start edge
  wire pipe_full = (latency_ff == 4'(sample_buffer_pkg::PIPE_LATENCY));
  wire cont_store = clk_fall && !single_mode && pipe_full;
  wire single_store = clk_fall && single_mode;

  // Both inputs frozen at the start edge, so a later B store stays simultaneous
  logic [sample_buffer_pkg::SAMPLE_W-1:0] held_ff [2];
  wire [sample_buffer_pkg::SAMPLE_W-1:0] live [2];
  assign live[0] = result_a_in;
  assign live[1] = result_b_in;

  // One hold register per input
  generate
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_hold
      always_ff @(posedge sys_clk_in)
      begin
        if (rst_in)
          held_ff[ch] <= '0;
        else if (single_store)
          held_ff[ch] <= live[ch];
      end
    end
  endgenerate

  // Scan order: channel A then channel B
  wire stage_valid = cont_store || single_store || second_pending_ff;
  wire stage_chan = second_pending_ff ? 1'b1 : (scan && !single_mode ? chan_ff : 1'b0);
  wire [sample_buffer_pkg::SAMPLE_W-1:0] stage_val = second_pending_ff ? held_ff[1] :
    (stage_chan ? result_b_in : result_a_in);
  sample_buffer_pkg::sample_s stage_word;
  assign stage_word = '{channel: stage_chan, value: stage_val};
  logic stage_ready;

  // Pipeline fill count after a buffer reset
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
      latency_ff <= '0;
    else if (clk_fall && !single_mode && !pipe_full)
      latency_ff <= latency_ff + 1'b1;
  end

  // Scan channel toggle, one step per continuous store
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
      chan_ff <= 1'b0;
    else if (cont_store && stage_ready)
      chan_ff <= scan ? !chan_ff : 1'b0;
  end

  // Single mode with scan: B follows A one cycle after the start edge
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
      second_pending_ff <= 1'b0;
    else if (single_store && scan)
      second_pending_ff <= 1'b1;
    else if (second_pending_ff && stage_ready)
      second_pending_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Staging FIFO between conversion and circular buffer

  logic drain_valid;
  logic drain_ready;
  logic [SW-1:0] drain_data;

  sample_fifo #(
    .WIDTH(SW),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .sys_clk_in(sys_clk_in),
    .rst_in(clear_all),
    .flush_in(1'b0),
    .in_valid_in(stage_valid),
    .in_ready_out(stage_ready),
    .in_data_in(stage_word),
    .out_valid_out(drain_valid),
    .out_ready_in(drain_ready),
    .out_data_out(drain_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Circular buffer with read and write pointers and a count of place within the block

  logic [SW-1:0] buf_mem [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] fill_ff;
  logic [4:0] since_trigger_ff;
  logic [11:0] bus_data_ff;
  logic bus_oe_ff;
  logic ready_n_ff;
  logic overflow_ff;
  logic hold_ff;
  logic started_ff;

  wire full = (fill_ff == (PW+1)'(DEPTH));
  // Drain stalls while full, back-pressure reaches staging FIFO
  assign drain_ready = !full;
  wire store = drain_valid && drain_ready;
  wire [PW-1:0] wr_next = (wr_ptr_ff == PW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
  wire [PW-1:0] store_slot = started_ff ? wr_next : wr_ptr_ff;
  wire empty = (fill_ff == '0);
  wire take = read_edge && !readback && !empty;
  wire [PW-1:0] rd_next = (rd_ptr_ff == PW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
  // Block begins at channel A in scan mode
  wire aligned = !scan || since_trigger_ff != '0 || !drain_data[SW-1];
  wire accept = store && aligned;
  wire trigger_hit = accept && (since_trigger_ff + 5'h01 == level);
  sample_buffer_pkg::sample_s head;
  assign head = buf_mem[rd_ptr_ff];
  // Readback: low trigger bit picks the second register, else the first
  wire readback_second = trigger_code[0];
  wire [9:0] first_word = conversion_setup_ff;
  wire [9:0] second_word = fifo_output_setup_ff;
  wire [11:0] reg_word = {2'h0, readback_second ? second_word : first_word};

  // Sample storage at slot after last written
  always_ff @(posedge sys_clk_in)
  begin
    if (accept)
      buf_mem[store_slot] <= drain_data;
  end

  // Write side: pointer to last written entry and place within the block
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
    begin
      wr_ptr_ff <= '0;
      started_ff <= 1'b0;
      since_trigger_ff <= '0;
    end
    else if (accept)
    begin
      wr_ptr_ff <= store_slot;
      started_ff <= 1'b1;
      since_trigger_ff <= trigger_hit ? '0 : since_trigger_ff + 5'h01;
    end
  end

  // Read side: pointer to next entry, moved only by an honoured read
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
      rd_ptr_ff <= '0;
    else if (take)
      rd_ptr_ff <= rd_next;
  end

  // Occupancy, the single source of the full and empty decisions
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
      fill_ff <= '0;
    else
      fill_ff <= fill_ff + (PW+1)'(accept) - (PW+1)'(take);
  end

  ////////////////////////////////////////////////////////////////////////
  // Block pulse and status flags

  // Data-available pulse, one cycle low per completed block
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
      ready_n_ff <= 1'b1;
    else
      ready_n_ff <= !trigger_hit;
  end

  // Sticky overflow: an arrival into a full buffer wins over a same-cycle clear
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      overflow_ff <= 1'b0;
    else
      overflow_ff <= (overflow_ff && !soft_reset && !buffer_reset) || (drain_valid && full);
  end

  // Hold strobe, one cycle after each single-mode start edge
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_all)
      hold_ff <= 1'b0;
    else
      hold_ff <= single_store;
  end

  ////////////////////////////////////////////////////////////////////////
  // Host read port

  // Output enable follows the qualified read one cycle late
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      bus_oe_ff <= 1'b0;
    else
      bus_oe_ff <= read_active;
  end

  // Read data: sample at read pointer, or a register in readback
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      bus_data_ff <= '0;
    else if (read_edge)
      bus_data_ff <= readback ? reg_word : head.value;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop

  assign bus_data_out = bus_data_ff;
  assign bus_data_oe_out = bus_oe_ff;
  assign samples_ready_n_out = ready_n_ff;
  assign overflow_out = overflow_ff;
  assign ref_external_out = conversion_setup_ff.ref_external;
  assign power_down_out = conversion_setup_ff.power_down;
  assign hold_out = hold_ff;
  // Host keeps to block size after each pulse
  // Single or continuous chosen by register bit
endmodule

// ==== verilog/sample_fifo.sv ====
`timescale 1ns/1ps
module sample_fifo #(
  parameter int unsigned WIDTH = 13,
  parameter int unsigned DEPTH = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] count_ff;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;

  // Honest full and empty from the occupancy count
  assign in_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (count_ff != '0);
  assign out_data_out = mem[rd_ff];

  // Storage
  always_ff @(posedge sys_clk_in)
  begin
    if (push)
      mem[wr_ff] <= in_data_in;
  end

  // Pointers and count
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || flush_in)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      if (pop)
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
